// ==== operand_address_generation.sv ====
// Operand address generator: request sequencing, opcode overrides, registered answers.
`timescale 1ns/10ps
`include "operand_addr_defines.svh"
module operand_address_generation (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         reqValid,
	input  wire logic [7:0]   opcode,
	input  wire logic [3:0]   addrMode,
	input  wire logic [2:0]   byteRegisterCode,
	input  wire logic [1:0]   registerPairCode,
	input  wire logic         wordAccess,
	input  wire logic [7:0]   imm8,
	input  wire logic [15:0]  absoluteAddressOperand,
	input  wire logic         bankSelectBit0,
	input  wire logic         bankSelectBit1,
	input  wire logic [255:0] generalRegs,
	input  wire logic [15:0]  stackPointerReg,
	output logic              ansValid,
	output logic [15:0]       memAddr,
	output logic              memValid,
	output logic              memWord,
	output logic              stackAccess,
	output logic [4:0]        regNumber,
	output logic              regValid,
	output logic [3:0]        pairNumber,
	output logic              pairValid,
	output logic [15:0]       product,
	output logic              productWrite,
	output logic              addrFault
);
	operand_calc_if c ();

	operand_addr_calc calcUnit (
		.c (c.calc)
	);

	operand_addr_pkg::gen_state_e state_ff;
	operand_addr_pkg::gen_state_e nxt_state;
	operand_addr_pkg::addr_mode_e effMode;
	logic        take;
	logic        effWord;
	logic [1:0]  effPair;
	logic        ansValid_ff;
	logic        nxt_ansValid;
	logic [15:0] memAddr_ff;
	logic [15:0] nxt_memAddr;
	logic        memValid_ff;
	logic        nxt_memValid;
	logic        memWord_ff;
	logic        nxt_memWord;
	logic        stack_ff;
	logic        nxt_stack;
	logic [4:0]  regNumber_ff;
	logic [4:0]  nxt_regNumber;
	logic        regValid_ff;
	logic        nxt_regValid;
	logic [3:0]  pairNumber_ff;
	logic [3:0]  nxt_pairNumber;
	logic        pairValid_ff;
	logic        nxt_pairValid;
	logic [15:0] product_ff;
	logic [15:0] nxt_product;
	logic        productWrite_ff;
	logic        nxt_productWrite;
	logic        fault_ff;
	logic        nxt_fault;

	// Two opcodes fix their own mode and pair, so the decode path need not set them.
	always_comb
	begin
		effMode = operand_addr_pkg::addr_mode_e'(addrMode);
		effPair = registerPairCode;
		effWord = wordAccess;
		if (opcode == `OPC_LOAD_A_DE)
		begin
			effMode = operand_addr_pkg::MODE_INDIRECT;
			effPair = `PAIR_DE;
			effWord = 1'b0;
		end
		else if (opcode == `OPC_PUSH_DE)
		begin
			effMode = operand_addr_pkg::MODE_PUSH;
			effPair = `PAIR_DE;
			effWord = 1'b1;
		end
	end

	assign c.mode                   = effMode;
	assign c.byteRegisterCode       = byteRegisterCode;
	assign c.registerPairCode       = effPair;
	assign c.bank                   = {bankSelectBit1, bankSelectBit0};
	assign c.wordAccess             = effWord;
	assign c.imm8                   = imm8;
	assign c.absoluteAddressOperand = absoluteAddressOperand;
	assign c.generalRegs            = generalRegs;
	assign c.stackPointerReg        = stackPointerReg;

	assign take = reqValid && (state_ff == operand_addr_pkg::ST_IDLE);

	// Valid strobes stand for exactly one cycle; a request in the answer cycle is dropped.
	always_comb
	begin
		nxt_state        = state_ff;
		nxt_ansValid     = 1'b0;
		nxt_memAddr      = memAddr_ff;
		nxt_memValid     = 1'b0;
		nxt_memWord      = memWord_ff;
		nxt_stack        = 1'b0;
		nxt_regNumber    = regNumber_ff;
		nxt_regValid     = 1'b0;
		nxt_pairNumber   = pairNumber_ff;
		nxt_pairValid    = 1'b0;
		nxt_product      = product_ff;
		nxt_productWrite = 1'b0;
		nxt_fault        = 1'b0;
		case (state_ff)
			operand_addr_pkg::ST_IDLE:
			begin
				if (take)
				begin
					nxt_state        = operand_addr_pkg::ST_ANSWER;
					nxt_ansValid     = 1'b1;
					nxt_memAddr      = c.addr;
					nxt_memValid     = c.addrOk;
					// Stack transfers always move a whole pair, whatever the decode path says.
					nxt_memWord      = effWord || c.stack;
					nxt_stack        = c.stack;
					nxt_regNumber    = c.regNum;
					nxt_regValid     = c.regOk;
					nxt_pairNumber   = c.pairNum;
					nxt_pairValid    = c.pairOk;
					nxt_product      = c.product;
					nxt_productWrite = c.productOk;
					nxt_fault        = c.fault;
				end
			end
			operand_addr_pkg::ST_ANSWER:
			begin
				nxt_state = operand_addr_pkg::ST_IDLE;
			end
			default:
			begin
				nxt_state = operand_addr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_ff        <= operand_addr_pkg::ST_IDLE;
			ansValid_ff     <= 1'b0;
			memAddr_ff      <= `ADDR_RESET;
			memValid_ff     <= 1'b0;
			memWord_ff      <= 1'b0;
			stack_ff        <= 1'b0;
			regNumber_ff    <= 5'h00;
			regValid_ff     <= 1'b0;
			pairNumber_ff   <= 4'h0;
			pairValid_ff    <= 1'b0;
			product_ff      <= 16'h0000;
			productWrite_ff <= 1'b0;
			fault_ff        <= 1'b0;
		end
		else
		begin
			state_ff        <= nxt_state;
			ansValid_ff     <= nxt_ansValid;
			memAddr_ff      <= nxt_memAddr;
			memValid_ff     <= nxt_memValid;
			memWord_ff      <= nxt_memWord;
			stack_ff        <= nxt_stack;
			regNumber_ff    <= nxt_regNumber;
			regValid_ff     <= nxt_regValid;
			pairNumber_ff   <= nxt_pairNumber;
			pairValid_ff    <= nxt_pairValid;
			product_ff      <= nxt_product;
			productWrite_ff <= nxt_productWrite;
			fault_ff        <= nxt_fault;
		end
	end

	assign ansValid     = ansValid_ff;
	assign memAddr      = memAddr_ff;
	assign memValid     = memValid_ff;
	assign memWord      = memWord_ff;
	assign stackAccess  = stack_ff;
	assign regNumber    = regNumber_ff;
	assign regValid     = regValid_ff;
	assign pairNumber   = pairNumber_ff;
	assign pairValid    = pairValid_ff;
	assign product      = product_ff;
	assign productWrite = productWrite_ff;
	assign addrFault    = fault_ff;

	answer_timing_a: assert property (@(posedge clk) disable iff (reset)
		take |=> ansValid_ff ##1 !ansValid_ff)
		else $error("Answer did not stand for exactly one cycle.");

	mul_target_a: assert property (@(posedge clk) disable iff (reset)
		productWrite_ff |-> pairNumber_ff[1:0] == `PAIR_AX && ansValid_ff &&
		product_ff == 16'($past(generalRegs[{bankSelectBit1, bankSelectBit0, `REG_A, 3'b000} +: 8]) *
		$past(generalRegs[{bankSelectBit1, bankSelectBit0, byteRegisterCode, 3'b000} +: 8])))
		else $error("Multiply product or target pair is wrong.");

	reg_select_a: assert property (@(posedge clk) disable iff (reset)
		regValid_ff |-> regNumber_ff == {$past(bankSelectBit1), $past(bankSelectBit0), $past(byteRegisterCode)})
		else $error("Byte register number does not follow bank and code.");

	direct_addr_a: assert property (@(posedge clk) disable iff (reset)
		take && effMode == operand_addr_pkg::MODE_DIRECT |=> memValid_ff && memAddr_ff == $past(absoluteAddressOperand))
		else $error("Direct address differs from the immediate.");

	short_addr_a: assert property (@(posedge clk) disable iff (reset)
		take && effMode == operand_addr_pkg::MODE_SHORT |=>
		memAddr_ff[15:8] == ($past(imm8) < `SHORT_LOW_LIMIT ? 8'hFF : 8'hFE) &&
		memAddr_ff[7:1] == $past(imm8[7:1]))
		else $error("Short direct address formed wrongly.");

	word_even_a: assert property (@(posedge clk) disable iff (reset)
		take && effWord && (effMode == operand_addr_pkg::MODE_SHORT || effMode == operand_addr_pkg::MODE_SFR)
		|=> !memAddr_ff[0])
		else $error("Word access produced an odd address.");

	sfr_addr_a: assert property (@(posedge clk) disable iff (reset)
		take && effMode == operand_addr_pkg::MODE_SFR && !effWord |=>
		memAddr_ff == {`SFR_PAGE, $past(imm8)} && memValid_ff != addrFault)
		else $error("Special register address formed wrongly.");

	based_sum_a: assert property (@(posedge clk) disable iff (reset)
		take && effMode == operand_addr_pkg::MODE_BASED |=>
		memAddr_ff == 16'($past(generalRegs[{bankSelectBit1, bankSelectBit0, `REG_H, 3'b000} +: 8]) * 256 +
		$past(generalRegs[{bankSelectBit1, bankSelectBit0, `REG_L, 3'b000} +: 8]) + $past(imm8)))
		else $error("Based address sum is wrong.");

	stack_ram_a: assert property (@(posedge clk) disable iff (reset)
		memValid_ff && stackAccess |-> memAddr_ff >= `HSRAM_LO && memAddr_ff < `HSRAM_HI)
		else $error("Stack access left high-speed RAM.");

	opcode_de_a: assert property (@(posedge clk) disable iff (reset)
		take && opcode == `OPC_LOAD_A_DE |=> !stackAccess && !memWord_ff &&
		memAddr_ff == {$past(generalRegs[{bankSelectBit1, bankSelectBit0, `REG_D, 3'b000} +: 8]),
		$past(generalRegs[{bankSelectBit1, bankSelectBit0, `REG_E, 3'b000} +: 8])})
		else $error("Indirect load did not use the third pair.");

	push_de_a: assert property (@(posedge clk) disable iff (reset)
		take && opcode == `OPC_PUSH_DE |=> stackAccess && pairValid_ff &&
		pairNumber_ff[1:0] == `PAIR_DE && memAddr_ff == 16'($past(stackPointerReg) - `STACK_PAIR_STEP))
		else $error("Push did not use the third pair below the stack pointer.");
endmodule

// ==== operand_addr_defines.svh ====
// Constants of the operand address generator: address limits, offsets, codes and reset values.
`ifndef OPERAND_ADDR_DEFINES_SVH
`define OPERAND_ADDR_DEFINES_SVH

`define SHORT_LOW_LIMIT   8'h20
`define SHORT_UPPER_BITS  7'h7F
`define SFR_PAGE          8'hFF
`define SFR_HOLE_LO       8'hD0
`define SFR_HOLE_HI       8'hDF
`define HSRAM_LO          16'hFE20
`define HSRAM_HI          16'hFEFF
`define STACK_PAIR_STEP   16'h0002
`define OPC_LOAD_A_DE     8'h85
`define OPC_PUSH_DE       8'hB5
`define REG_X             3'h0
`define REG_A             3'h1
`define REG_C             3'h2
`define REG_B             3'h3
`define REG_E             3'h4
`define REG_D             3'h5
`define REG_L             3'h6
`define REG_H             3'h7
`define PAIR_AX           2'h0
`define PAIR_BC           2'h1
`define PAIR_DE           2'h2
`define PAIR_HL           2'h3
`define ADDR_RESET        16'h0000

`endif

// ==== operand_addr_pkg.sv ====
// Types shared by the operand address generator.
package operand_addr_pkg;

	typedef enum logic [3:0] {
		MODE_IMPLIED   = 4'h0,
		MODE_REGISTER  = 4'h1,
		MODE_DIRECT    = 4'h2,
		MODE_SHORT     = 4'h3,
		MODE_SFR       = 4'h4,
		MODE_INDIRECT  = 4'h5,
		MODE_BASED     = 4'h6,
		MODE_BASED_IDX = 4'h7,
		MODE_PUSH      = 4'h8,
		MODE_POP       = 4'h9
	} addr_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_ANSWER = 2'b10
	} gen_state_e;

endpackage

// ==== operand_calc_if.sv ====
// Carrier between the sequencer and the address arithmetic.
`timescale 1ns/10ps
interface operand_calc_if;
	operand_addr_pkg::addr_mode_e mode;
	logic [2:0]   byteRegisterCode;
	logic [1:0]   registerPairCode;
	logic [1:0]   bank;
	logic         wordAccess;
	logic [7:0]   imm8;
	logic [15:0]  absoluteAddressOperand;
	logic [255:0] generalRegs;
	logic [15:0]  stackPointerReg;
	logic [15:0]  addr;
	logic         addrOk;
	logic         stack;
	logic         fault;
	logic [4:0]   regNum;
	logic         regOk;
	logic [3:0]   pairNum;
	logic         pairOk;
	logic [15:0]  product;
	logic         productOk;

	modport calc (
		input  mode, byteRegisterCode, registerPairCode, bank, wordAccess, imm8,
		input  absoluteAddressOperand, generalRegs, stackPointerReg,
		output addr, addrOk, stack, fault, regNum, regOk, pairNum, pairOk, product, productOk
	);
	modport user (
		output mode, byteRegisterCode, registerPairCode, bank, wordAccess, imm8,
		output absoluteAddressOperand, generalRegs, stackPointerReg,
		input  addr, addrOk, stack, fault, regNum, regOk, pairNum, pairOk, product, productOk
	);
endinterface

// ==== operand_addr_calc.sv ====
// Combinational address arithmetic for every operand addressing mode.
`timescale 1ns/10ps
`include "operand_addr_defines.svh"
module operand_addr_calc (
	operand_calc_if.calc c
);
	function automatic logic [7:0] regByte(input logic [255:0] regs, input logic [4:0] num);
		regByte = regs[{num, 3'b000} +: 8];
	endfunction

	function automatic logic [15:0] regPair(input logic [255:0] regs, input logic [1:0] bank, input logic [1:0] pc);
		regPair = {regByte(regs, {bank, pc, 1'b1}), regByte(regs, {bank, pc, 1'b0})};
	endfunction

	function automatic logic inHsram(input logic [15:0] a);
		inHsram = (a >= `HSRAM_LO) && (a <= `HSRAM_HI);
	endfunction

	logic [15:0] basePair;
	logic [15:0] stackAddr;

	always_comb
	begin
		basePair    = regPair(c.generalRegs, c.bank, `PAIR_HL);
		stackAddr   = c.stackPointerReg;
		c.addr      = `ADDR_RESET;
		c.addrOk    = 1'b0;
		c.stack     = 1'b0;
		c.fault     = 1'b0;
		c.regNum    = {c.bank, c.byteRegisterCode};
		c.regOk     = 1'b0;
		c.pairNum   = {c.bank, c.registerPairCode};
		c.pairOk    = 1'b0;
		c.product   = 16'h0000;
		c.productOk = 1'b0;
		case (c.mode)
			operand_addr_pkg::MODE_IMPLIED:
			begin
				c.product   = 16'(regByte(c.generalRegs, {c.bank, `REG_A}) *
					regByte(c.generalRegs, {c.bank, c.byteRegisterCode}));
				c.productOk = 1'b1;
				c.pairNum   = {c.bank, `PAIR_AX};
			end
			operand_addr_pkg::MODE_REGISTER:
			begin
				c.regOk  = !c.wordAccess;
				c.pairOk = c.wordAccess;
			end
			operand_addr_pkg::MODE_DIRECT:
			begin
				c.addr   = c.absoluteAddressOperand;
				c.addrOk = 1'b1;
			end
			operand_addr_pkg::MODE_SHORT:
			begin
				c.addr   = {`SHORT_UPPER_BITS, (c.imm8 < `SHORT_LOW_LIMIT),
					c.imm8[7:1], c.imm8[0] & !c.wordAccess};
				c.addrOk = 1'b1;
			end
			operand_addr_pkg::MODE_SFR:
			begin
				c.addr   = {`SFR_PAGE, c.imm8[7:1], c.imm8[0] & !c.wordAccess};
				c.fault  = (c.imm8 >= `SFR_HOLE_LO) && (c.imm8 <= `SFR_HOLE_HI);
				c.addrOk = !c.fault;
			end
			operand_addr_pkg::MODE_INDIRECT:
			begin
				c.addr   = regPair(c.generalRegs, c.bank, c.registerPairCode);
				c.addrOk = 1'b1;
			end
			operand_addr_pkg::MODE_BASED:
			begin
				c.addr   = 16'(basePair + {8'h00, c.imm8});
				c.addrOk = 1'b1;
			end
			operand_addr_pkg::MODE_BASED_IDX:
			begin
				c.addr   = 16'(basePair + {8'h00, regByte(c.generalRegs, {c.bank, c.byteRegisterCode})});
				c.addrOk = 1'b1;
			end
			operand_addr_pkg::MODE_PUSH, operand_addr_pkg::MODE_POP:
			begin
				// A push writes the pair below the current top, so the pointer drops first.
				if (c.mode == operand_addr_pkg::MODE_PUSH)
					stackAddr = 16'(c.stackPointerReg - `STACK_PAIR_STEP);
				c.addr   = stackAddr;
				c.stack  = 1'b1;
				c.pairOk = 1'b1;
				c.fault  = !inHsram(stackAddr) || !inHsram(16'(stackAddr + 16'h0001));
				c.addrOk = !c.fault;
			end
			default:
			begin
				c.fault = 1'b1;
			end
		endcase
	end
endmodule

// ==== reg_space_model.sv ====
// Far-side model: four banks of general registers and the stack pointer that feed the generator.
`timescale 1ns/10ps
module reg_space_model (
	input  wire logic         clk,
	input  wire logic         loadEn,
	input  wire logic [255:0] loadRegs,
	input  wire logic [15:0]  loadSp,
	input  wire logic         productWrite,
	input  wire logic [3:0]   pairNumber,
	input  wire logic [15:0]  product,
	output logic      [255:0] generalRegs,
	output logic      [15:0]  stackPointerReg
);
	initial
	begin
		generalRegs = '0;
		stackPointerReg = 16'h0000;
	end
	// A bench load wins over a product write, so the bench copy stays the only source of truth.
	always @(posedge clk)
	begin
		if (loadEn)
		begin
			generalRegs <= loadRegs;
			stackPointerReg <= loadSp;
		end
		else if (productWrite)
			generalRegs[{pairNumber, 4'h0} +: 16] <= product;
	end
endmodule

// ==== tb.sv ====
// Self-checking bench for the operand address generator with a behavioural reference.
`timescale 1ns/10ps
module tb;
	logic         clk, reset, reqValid, wordAccess, bankSelectBit0, bankSelectBit1, loadEn;
	logic [7:0]   opcode, imm8;
	logic [3:0]   addrMode, pairNumber;
	logic [2:0]   byteRegisterCode;
	logic [1:0]   registerPairCode;
	logic [15:0]  absoluteAddressOperand, stackPointerReg, loadSp, memAddr, product;
	logic [255:0] generalRegs, loadRegs;
	logic         ansValid, memValid, memWord, stackAccess, regValid, pairValid, productWrite, addrFault;
	logic [4:0]   regNumber;
	logic [7:0]   mdl [32];
	logic [3:0]   rMode;
	logic [7:0]   rOpc, rImm;
	logic [2:0]   rCode;
	logic [1:0]   rPair, rBank, ep;
	logic [15:0]  rAbs, rSp, eAddr, eProd;
	logic         rWord, rRefuse, eMem, eFault, ePairV, eRegV;
	logic [31:0]  r;
	int           em, errors, comparisons, seed;
	logic [7:0]   edgeImm [8] = '{8'h00, 8'h1F, 8'h20, 8'hFF, 8'hCF, 8'hD0, 8'hDF, 8'hE0};
	logic [15:0]  spTab [8] = '{16'hFE22, 16'hFE21, 16'hFF00, 16'hFF01, 16'hFEFE, 16'hFEFF, 16'hFE1F, 16'hFE20};

	operand_address_generation dut_u (.clk(clk), .reset(reset), .reqValid(reqValid), .opcode(opcode),
		.addrMode(addrMode), .byteRegisterCode(byteRegisterCode), .registerPairCode(registerPairCode),
		.wordAccess(wordAccess), .imm8(imm8), .absoluteAddressOperand(absoluteAddressOperand),
		.bankSelectBit0(bankSelectBit0), .bankSelectBit1(bankSelectBit1), .generalRegs(generalRegs),
		.stackPointerReg(stackPointerReg), .ansValid(ansValid), .memAddr(memAddr), .memValid(memValid),
		.memWord(memWord), .stackAccess(stackAccess), .regNumber(regNumber), .regValid(regValid),
		.pairNumber(pairNumber), .pairValid(pairValid), .product(product), .productWrite(productWrite),
		.addrFault(addrFault));
	reg_space_model regs_u (.clk(clk), .loadEn(loadEn), .loadRegs(loadRegs), .loadSp(loadSp),
		.productWrite(productWrite), .pairNumber(pairNumber), .product(product),
		.generalRegs(generalRegs), .stackPointerReg(stackPointerReg));

	function automatic logic [7:0] byteOf(input logic [1:0] b, input logic [2:0] c);
		return mdl[{b, c}];
	endfunction
	function automatic logic [15:0] pairOf(input logic [1:0] b, input logic [1:0] p);
		return {mdl[{b, p, 1'b1}], mdl[{b, p, 1'b0}]};
	endfunction
	function automatic logic [255:0] packRegs;
		for (int n = 0; n < 32; n++)
			packRegs[8*n +: 8] = mdl[n];
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic calc;
		logic [15:0] base;
		em = (rOpc == 8'h85) ? 5 : (rOpc == 8'hB5) ? 8 : rMode;
		ep = (rOpc == 8'h85 || rOpc == 8'hB5) ? 2'h2 : rPair;
		base = pairOf(rBank, 2'h3);
		{eMem, eFault, ePairV, eRegV} = 4'h8;
		eAddr = 16'h0000;
		eProd = byteOf(rBank, 3'h1) * byteOf(rBank, rCode);
		case (em)
			0: eMem = 1'b0;
			1: {eMem, ePairV, eRegV} = {1'b0, rWord, !rWord};
			2: eAddr = rAbs;
			3: eAddr = {7'h7F, rImm < 8'h20, rImm};
			4: {eAddr, eFault} = {8'hFF, rImm, rImm[7:4] == 4'hD};
			5: eAddr = pairOf(rBank, ep);
			6: eAddr = base + {8'h00, rImm};
			7: eAddr = base + {8'h00, byteOf(rBank, rCode)};
			8: eAddr = rSp - 16'h0002;
			9: eAddr = rSp;
			default: eFault = 1'b1;
		endcase
		if (em == 8 || em == 9)
			{ePairV, eFault} = {1'b1, eAddr < 16'hFE20 || eAddr > 16'hFEFE};
		if (eFault)
			eMem = 1'b0;
	endtask

	task automatic look;
		chk("ansValid", ansValid, 1'b1);
		chk("memValid", memValid, eMem);
		chk("addrFault", addrFault, eFault);
		chk("productWrite", productWrite, em == 0);
		chk("regValid", regValid, eRegV);
		if (eRegV) chk("regNumber", regNumber, {rBank, rCode});
		if (em == 0) chk("product", product, eProd);
		if (em == 0) chk("pairNumber", pairNumber, {rBank, 2'h0});
		if (em != 0 && !eFault) chk("pairValid", pairValid, ePairV);
		if (ePairV && !eFault) chk("pairNumber", pairNumber, {rBank, ep});
		if (!eFault) chk("stackAccess", stackAccess, em >= 8);
		if (eMem && em inside {3, 4, 8, 9}) chk("memWord", memWord, em >= 8 || rWord);
		if (eMem)
			case (em)
				2: chk("memAddr", memAddr, eAddr);
				3: chk("memAddr", memAddr, eAddr);
				4: chk("memAddr", memAddr, eAddr);
				5: chk("memAddr", memAddr, eAddr);
				6: chk("memAddr", memAddr, eAddr);
				7: chk("memAddr", memAddr, eAddr);
				default: chk("memAddr", memAddr, eAddr);
			endcase
	endtask

	// A request is followed by a held strobe in the answer cycle when rRefuse is set, which must be ignored.
	task automatic go;
		@(posedge clk);
		{loadEn, loadRegs, loadSp} <= {1'b1, packRegs(), rSp};
		@(posedge clk);
		{loadEn, reqValid, opcode, addrMode, byteRegisterCode} <= {2'b01, rOpc, rMode, rCode};
		{registerPairCode, wordAccess, imm8, absoluteAddressOperand} <= {rPair, rWord, rImm, rAbs};
		{bankSelectBit1, bankSelectBit0} <= rBank;
		@(posedge clk);
		{reqValid, addrMode} <= {rRefuse, 4'h2};
		#1;
		calc();
		look();
		@(posedge clk);
		reqValid <= 1'b0;
		#1;
		chk("ansValid", ansValid, 1'b0);
		if (em == 0)
			{mdl[{rBank, 3'h1}], mdl[{rBank, 3'h0}]} = eProd;
	endtask

	task automatic dir(input logic [3:0] m, input logic [7:0] opc, input logic [7:0] imm, input logic [15:0] sp);
		{rMode, rOpc, rImm, rSp, rCode, rPair, rWord, rBank, rRefuse} = {m, opc, imm, sp, 3'h2, 2'h1, 1'b0, 2'h3, 1'b1};
		rAbs = 16'hFE00;
		go();
	endtask

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		repeat (100000) @(posedge clk);
		errors++;
		stop_test();
	end

	initial
	begin
		{reset, reqValid, wordAccess, bankSelectBit0, bankSelectBit1, loadEn} = 6'h20;
		{opcode, imm8, addrMode, byteRegisterCode, registerPairCode} = '0;
		{absoluteAddressOperand, loadSp, loadRegs} = '0;
		{errors, comparisons, seed} = {32'h0, 32'h0, 32'h2D};
		for (int n = 0; n < 32; n++)
			mdl[n] = 8'h11 * n[7:0];
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("ansValid", ansValid, 1'b0);
		chk("memValid", memValid, 1'b0);
		for (int m = 0; m < 16; m++)
			dir(m[3:0], 8'h00, 8'h40, 16'hFE80);
		foreach (edgeImm[i])
			dir((i < 4) ? 4'h3 : 4'h4, 8'h00, edgeImm[i], 16'hFE80);
		foreach (spTab[i])
			dir((i < 4) ? 4'h8 : 4'h9, 8'h00, 8'h00, spTab[i]);
		dir(4'h2, 8'h85, 8'h00, 16'hFE80);
		dir(4'h2, 8'hB5, 8'h00, 16'hFE80);
		{mdl[{2'h3, 3'h7}], mdl[{2'h3, 3'h6}], mdl[{2'h3, 3'h2}]} = 24'hFFFF80;
		dir(4'h6, 8'h00, 8'hFF, 16'hFE80);
		dir(4'h7, 8'h00, 8'h00, 16'hFE80);
		repeat (1500)
		begin
			r = $random(seed);
			rMode = r[3:0];
			if (rMode > 9 && r[4])
				rMode = rMode - 4'h6;
			rOpc = (r[15:8] == 8'h85 || r[15:8] == 8'hB5) ? 8'h00 : r[15:8];
			if (r[18:16] == 3'h0)
				rOpc = 8'h85;
			if (r[18:16] == 3'h1)
				rOpc = 8'hB5;
			{rCode, rPair, rWord, rBank, rRefuse} = r[27:19];
			if (rMode == 7)
				rCode = {2'h1, r[19]};
			r = $random(seed);
			{rAbs, rImm} = {r[31:16], r[7:0]};
			if (rWord && (rMode == 3 || rMode == 4))
				rImm[0] = 1'b0;
			rSp = 16'hFE10 + {7'h00, r[16:8]};
			for (int n = 0; n < 32; n++)
				if (r[n] && r[0])
					mdl[n] = 8'($random(seed));
			go();
		end
		@(posedge clk);
		{reset, reqValid, addrMode} <= {2'b11, 4'h2};
		repeat (2) @(posedge clk);
		{reset, reqValid} <= 2'b00;
		#1;
		chk("ansValid", ansValid, 1'b0);
		dir(4'h3, 8'h00, 8'h10, 16'hFE80);
		stop_test();
	end
endmodule
